// [rtl/add_and_alu_ops.sv]
// Accumulator datapath executing the add and AND instruction group
// How it works
// - add immediate: accumulator plus literal, all flags
// - and immediate: accumulator AND literal, zero only
// - add register: accumulator plus register, all flags
// - and register: accumulator AND register, zero only
// - target bit zero: result to accumulator
// - register forms with target bit one: result to register
`timescale 1ns/10ps
module add_and_alu_ops (
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        insn_valid,
    input  wire logic [13:0] insn,
    output logic      [6:0]  reg_index,
    input  wire logic [7:0]  reg_rdata,
    output logic             reg_we,
    output logic      [6:0]  reg_waddr,
    output logic      [7:0]  reg_wdata,
    output logic      [7:0]  acc,
    output logic             carry_flag,
    output logic             half_carry_flag,
    output logic             zero_flag,
    output logic             insn_done
);
    // ****************************************************************
    // Decode
    // ****************************************************************
    logic             is_add_imm;
    logic             is_and_imm;
    logic             is_add_reg;
    logic             is_and_reg;
    logic             is_reg_op;
    logic             to_reg;
    alu_pkg::alu_op_e op;
    logic [7:0]       opnd_b;
    logic [7:0]       result;
    logic             c_out;
    logic             dc_out;
    logic             z_out;

    // Register read address is combinational from the instruction
    // No forwarding here: the file must forward a pending write to a read of the same index
    assign reg_index = insn[alu_pkg::INDEX_W-1:0];

    // Add immediate ignores opcode bit 8
    always_comb begin
        is_add_imm = insn[alu_pkg::OPC_HI:alu_pkg::OPC5_LO] == alu_pkg::OPC_ADD_IMM;
        is_and_imm = insn[alu_pkg::OPC_HI:alu_pkg::OPC6_LO] == alu_pkg::OPC_AND_IMM;
        is_add_reg = insn[alu_pkg::OPC_HI:alu_pkg::OPC6_LO] == alu_pkg::OPC_ADD_REG;
        is_and_reg = insn[alu_pkg::OPC_HI:alu_pkg::OPC6_LO] == alu_pkg::OPC_AND_REG;
        is_reg_op  = is_add_reg | is_and_reg;
        to_reg     = is_reg_op & insn[alu_pkg::DEST_BIT];
        op         = (is_add_imm | is_add_reg) ? alu_pkg::ALU_ADD : alu_pkg::ALU_AND;
        opnd_b     = is_reg_op ? reg_rdata : insn[7:0];
    end

    alu_core u_alu (
        .opnd_a     (acc),
        .opnd_b     (opnd_b),
        .op         (op),
        .result     (result),
        .carry      (c_out),
        .half_carry (dc_out),
        .zero       (z_out)
    );

    // ****************************************************************
    // State update
    // ****************************************************************
    logic [7:0] nxt_acc;
    logic       nxt_c;
    logic       nxt_dc;
    logic       nxt_z;
    logic       nxt_we;
    logic [6:0] nxt_waddr;
    logic [7:0] nxt_wdata;
    logic       nxt_done;
    logic [7:0] acc_ff;
    logic       c_ff;
    logic       dc_ff;
    logic       z_ff;
    logic       we_ff;
    logic [6:0] waddr_ff;
    logic [7:0] wdata_ff;
    logic       done_ff;
    logic       hit;

    always_comb begin
        // Idle cycles and other opcodes hold accumulator, flags, write address and data; reg_we and insn_done drop
        hit       = insn_valid & (is_add_imm | is_and_imm | is_reg_op);
        nxt_acc   = acc_ff;
        nxt_c     = c_ff;
        nxt_dc    = dc_ff;
        nxt_z     = z_ff;
        nxt_we    = 1'b0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        nxt_done  = hit;
        if (hit) begin
            // The zero flag follows every taken instruction, whatever the target
            nxt_z = z_out;
            // AND keeps carry and half carry as they were
            if (op == alu_pkg::ALU_ADD) begin
                nxt_c  = c_out;
                nxt_dc = dc_out;
            end
            // Write-back leaves the accumulator untouched
            if (to_reg) begin
                nxt_we    = 1'b1;
                nxt_waddr = reg_index;
                nxt_wdata = result;
            end else begin
                nxt_acc = result;
            end
        end
    end

    // Reset clears at once, not at the next edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            acc_ff   <= alu_pkg::ACC_RST;
            c_ff     <= alu_pkg::FLAG_RST;
            dc_ff    <= alu_pkg::FLAG_RST;
            z_ff     <= alu_pkg::FLAG_RST;
            we_ff    <= 1'b0;
            waddr_ff <= alu_pkg::INDEX_RST;
            wdata_ff <= alu_pkg::DATA_RST;
            done_ff  <= 1'b0;
        end else begin
            acc_ff   <= nxt_acc;
            c_ff     <= nxt_c;
            dc_ff    <= nxt_dc;
            z_ff     <= nxt_z;
            we_ff    <= nxt_we;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
            done_ff  <= nxt_done;
        end
    end

    assign acc             = acc_ff;
    assign carry_flag      = c_ff;
    assign half_carry_flag = dc_ff;
    assign zero_flag       = z_ff;
    assign reg_we          = we_ff;
    assign reg_waddr       = waddr_ff;
    assign reg_wdata       = wdata_ff;
    assign insn_done       = done_ff;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_add_imm_sum: assert property (insn_valid && is_add_imm |=>
        acc == 8'($past(acc) + $past(insn[7:0])))
        else $error("add immediate sum wrong");
    a_and_imm_res: assert property (insn_valid && is_and_imm |=>
        acc == ($past(acc) & $past(insn[7:0])) && $stable(carry_flag)
        && $stable(half_carry_flag))
        else $error("and immediate result or flags wrong");
    a_add_reg_flag: assert property (insn_valid && is_add_reg |=>
        carry_flag == $past(9'({1'b0, acc} + {1'b0, reg_rdata}) >> 8))
        else $error("add register carry wrong");
    a_and_reg_keep: assert property (insn_valid && is_and_reg |=>
        $stable(carry_flag) && zero_flag == (($past(acc) & $past(reg_rdata)) == 8'h00))
        else $error("and register flags wrong");
    a_dest_acc: assert property (insn_valid && is_reg_op && !insn[7] |=>
        !reg_we)
        else $error("register written with target bit zero");
    a_dest_reg: assert property (insn_valid && is_reg_op && insn[7] |=>
        reg_we && $stable(acc) && reg_waddr == $past(insn[6:0]))
        else $error("register writeback wrong");
    a_half_carry: assert property (insn_valid && is_add_imm |=>
        half_carry_flag == $past(5'({1'b0, acc[3:0]} + {1'b0, insn[3:0]}) >> 4))
        else $error("half carry wrong");
    a_zero_flag: assert property (insn_valid && is_add_imm && !to_reg |=>
        zero_flag == (acc == 8'h00))
        else $error("zero flag wrong");

    // Operands are those seen at the taking edge
    a_add_imm_carry: assert property (insn_valid && is_add_imm |=>
        carry_flag == $past(9'({1'b0, acc} + {1'b0, insn[7:0]}) > 9'h0FF))
        else $error("add immediate carry wrong");
    a_and_imm_zero: assert property (insn_valid && is_and_imm |=>
        zero_flag == (acc == 8'h00))
        else $error("and immediate zero flag wrong");
    a_add_reg_acc: assert property (insn_valid && is_add_reg && !insn[7] |=>
        acc == 8'($past(acc) + $past(reg_rdata)))
        else $error("add register sum wrong");
    a_and_reg_acc: assert property (insn_valid && is_and_reg && !insn[7] |=>
        acc == ($past(acc) & $past(reg_rdata)))
        else $error("and register result wrong");
    a_and_reg_half: assert property (insn_valid && is_and_reg |=>
        $stable(half_carry_flag))
        else $error("and register half carry changed");
    a_add_reg_wb: assert property (insn_valid && is_add_reg && insn[7] |=>
        reg_wdata == 8'($past(acc) + $past(reg_rdata)))
        else $error("add register write data wrong");
    a_and_reg_wb: assert property (insn_valid && is_and_reg && insn[7] |=>
        reg_wdata == ($past(acc) & $past(reg_rdata)))
        else $error("and register write data wrong");
    a_we_only_wb: assert property (!(insn_valid && is_reg_op && insn[7]) |=>
        !reg_we)
        else $error("register written without write back");
    a_add_reg_half: assert property (insn_valid && is_add_reg |=>
        half_carry_flag == $past(5'({1'b0, acc[3:0]} + {1'b0, reg_rdata[3:0]}) > 5'h0F))
        else $error("add register half carry wrong");
    a_add_reg_zero: assert property (insn_valid && is_add_reg |=>
        zero_flag == ($past(8'({1'b0, acc} + {1'b0, reg_rdata})) == 8'h00))
        else $error("add register zero flag wrong");

    // ****************************************************************
    // Coverage
    // ****************************************************************
    // Main scenarios: add, and, both write-back paths
    c_add_imm: cover property (insn_valid && is_add_imm ##1 carry_flag);
    c_and_imm: cover property (insn_valid && is_and_imm ##1 zero_flag);
    c_reg_wb:  cover property (insn_valid && is_add_reg && insn[7] ##1 reg_we);
    c_and_acc: cover property (insn_valid && is_and_reg && !insn[7]);
    c_and_reg_wb: cover property (insn_valid && is_and_reg && insn[7] ##1 reg_we);
endmodule : add_and_alu_ops

// [rtl/alu_pkg.sv]
// Constants and types shared by the accumulator datapath and its ALU
package alu_pkg;
    localparam int unsigned DATA_W     = 8;
    localparam int unsigned INSN_W     = 14;
    localparam int unsigned INDEX_W    = 7;
    // Opcode fields
    localparam int unsigned OPC_HI     = 13;
    localparam int unsigned OPC6_LO    = 8;
    localparam int unsigned OPC5_LO    = 9;
    localparam int unsigned DEST_BIT   = 7;
    localparam logic [5:0]  OPC_AND_IMM = 6'h39;
    localparam logic [4:0]  OPC_ADD_IMM = 5'h1F;
    localparam logic [5:0]  OPC_ADD_REG = 6'h07;
    localparam logic [5:0]  OPC_AND_REG = 6'h05;
    // Values after reset
    localparam logic [7:0]  ACC_RST    = 8'h00;
    localparam logic        FLAG_RST   = 1'b0;
    localparam logic [7:0]  DATA_RST   = 8'h00;
    localparam logic [6:0]  INDEX_RST  = 7'h00;

    typedef enum logic [1:0] {
        ALU_ADD = 2'h1,
        ALU_AND = 2'h2
    } alu_op_e;
endpackage : alu_pkg

// [rtl/alu_core.sv]
// Combinational 8-bit add/AND unit with carry, half-carry and zero
`timescale 1ns/10ps
module alu_core (
    input  wire logic [7:0]       opnd_a,
    input  wire logic [7:0]       opnd_b,
    input  wire alu_pkg::alu_op_e op,
    output logic      [7:0]       result,
    output logic                  carry,
    output logic                  half_carry,
    output logic                  zero
);
    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb begin
        sum        = {1'b0, opnd_a} + {1'b0, opnd_b};
        low_sum    = {1'b0, opnd_a[3:0]} + {1'b0, opnd_b[3:0]};
        result     = (op == alu_pkg::ALU_ADD) ? sum[7:0] : (opnd_a & opnd_b);
        carry      = sum[8];
        half_carry = low_sum[4];
        zero       = (result == 8'h00);
    end
endmodule : alu_core

// [testbench/reg_file_model.sv]
// File register array model facing the datapath
`timescale 1ns/10ps
module reg_file_model (
    input  wire logic       clk_sys,
    input  wire logic [6:0] reg_index,
    output logic      [7:0] reg_rdata,
    input  wire logic       reg_we,
    input  wire logic [6:0] reg_waddr,
    input  wire logic [7:0] reg_wdata
);
    logic [7:0] mem [128];
    initial begin
        for (int i = 0; i < 128; i++) begin
            mem[i] = 8'(i) ^ 8'hC2;
        end
    end
    // Combinational read, write commits on the edge after reg_we
    // A write not yet committed is forwarded to a read of the same index
    assign reg_rdata = (reg_we === 1'b1 && reg_waddr == reg_index) ? reg_wdata
                                                                  : mem[reg_index];
    always @(posedge clk_sys) begin
        if (reg_we === 1'b1) begin
            mem[reg_waddr] <= reg_wdata;
        end
    end
endmodule : reg_file_model

// [testbench/tb_top.sv]
// Self-checking bench for the add and AND datapath
`timescale 1ns/10ps
module tb_top;
    logic clk_sys, rst_n, insn_valid, reg_we, cf, hf, zf, insn_done;
    logic [13:0] insn;
    logic [6:0]  reg_index, reg_waddr;
    logic [7:0]  reg_rdata, reg_wdata, acc, ra;
    logic        rc, rh, rz;
    int          failures, samples_checked, cycles;
    add_and_alu_ops dut (.clk_sys(clk_sys), .rst_n(rst_n), .insn_valid(insn_valid),
        .insn(insn), .reg_index(reg_index), .reg_rdata(reg_rdata), .reg_we(reg_we),
        .reg_waddr(reg_waddr), .reg_wdata(reg_wdata), .acc(acc), .carry_flag(cf),
        .half_carry_flag(hf), .zero_flag(zf), .insn_done(insn_done));
    reg_file_model u_regs (.clk_sys(clk_sys), .reg_index(reg_index), .reg_rdata(reg_rdata),
        .reg_we(reg_we), .reg_waddr(reg_waddr), .reg_wdata(reg_wdata));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            failures++;
            print_verdict();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("unexpected t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Issues one word, predicts the outcome and checks it; gap adds an idle cycle
    task automatic exec(input logic [13:0] w, input bit gap);
        logic [7:0] b, r;
        logic [8:0] s;
        logic       add, rop, ok, wr;
        rop = (w[13:12] == 2'h0);
        b   = rop ? u_regs.mem[w[6:0]] : w[7:0];
        add = (w[13:9] == 5'h1F) || (w[13:8] == 6'h07);
        ok  = add || (w[13:8] == 6'h39) || (w[13:8] == 6'h05);
        wr  = ok && rop && w[7];
        s   = {1'b0, ra} + {1'b0, b};
        r   = add ? s[7:0] : (ra & b);
        insn_valid = 1'b1;
        insn       = w;
        @(posedge clk_sys);
        #1;
        if (ok) begin
            if (add) begin
                rc = s[8];
                rh = ({1'b0, ra[3:0]} + {1'b0, b[3:0]}) > 5'h0F;
            end
            rz = (r == 8'h00);
            if (!wr) ra = r;
        end
        chk(acc, ra);
        chk({5'h0, cf, hf, zf}, {5'h0, rc, rh, rz});
        chk({6'h0, insn_done, reg_we}, {6'h0, ok, wr});
        if (wr) chk({1'b0, reg_waddr}, {1'b0, w[6:0]});
        if (wr) chk(reg_wdata, r);
        chk({1'b0, reg_index}, {1'b0, w[6:0]});
        if (gap) begin
            insn_valid = 1'b0;
            @(posedge clk_sys);
            #1;
            chk({6'h0, insn_done, reg_we}, 8'h00);
        end
    endtask : exec
    task automatic s_imm();
        exec(14'h3E10, 0);
        exec(14'h3E15, 0);
        exec(14'h3FDB, 0);
        exec(14'h395F, 0);
        exec(14'h3E80, 0);
        exec(14'h3E93, 0);
        exec(14'h395F, 0);
        exec(14'h3900, 1);
        $display("test immediate done");
    endtask : s_imm
    task automatic s_reg();
        exec(14'h3E17, 0);
        exec(14'h0705, 0);
        exec(14'h07FF, 1);
        exec(14'h0505, 0);
        exec(14'h0585, 1);
        exec(14'h07FF, 1);
        $display("test register done");
    endtask : s_reg
    task automatic s_refused();
        exec(14'h0E55, 0);
        exec(14'h3000, 1);
        $display("test refused done");
    endtask : s_refused
    // Mid-run reset clears outputs at once; the first word after release is taken
    task automatic s_reset();
        rst_n = 1'b0;
        #1;
        chk(acc, 8'h00);
        chk({5'h0, cf, hf, zf}, 8'h00);
        chk({1'b0, reg_waddr}, 8'h00);
        chk(reg_wdata, 8'h00);
        chk({6'h0, insn_done, reg_we}, 8'h00);
        {ra, rc, rh, rz} = 11'h000;
        repeat (3) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        exec(14'h3E15, 0);
        exec(14'h0785, 1);
        $display("test reset done");
    endtask : s_reset
    initial begin
        rst_n = 1'b0;
        insn_valid = 1'b0;
        insn = 14'h0000;
        {ra, rc, rh, rz} = 11'h000;
        repeat (8) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        s_imm();
        s_reg();
        s_refused();
        s_reset();
        print_verdict();
    end
endmodule : tb_top
